// [src/bfc_ctrl.sv]
// Control core: brightness code, on/off latch, error status and overheat shutdown
// Assumes the host serial front end presents parallel words and a latch strobe
// Behaviour
// RULE_01: One seven-bit brightness code for all channels
// RULE_02: Code selects among 128 equal levels
// RULE_03: Level equals full scale times code over 127
// RULE_04: Host loads code, device latches it
// RULE_05: Per-channel on/off data switches each output
// RULE_06: Six distinct error indications are kept
// RULE_07: Status results are shifted out to host
// RULE_08: Overheat forces every output off
// RULE_09: Overheat shutdown forces open status ones
// RULE_10: Outputs resume once overheat input clears
// RULE_11: Error flag holds until latch strobe
// RULE_12: On/off latch updates only on strobe
// RULE_13: Select 01 with overheat gives all ones
// RULE_14: Open status reported only for enabled channels
// RULE_15: Overheat input is synchronised before use
module bfc_ctrl
  import bfc_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic                          clk_en,
  input  wire logic                          latch_strobe,
  input  wire logic                          load_control,
  input  wire logic [bfc_pkg::BC_W-1:0]      shift_bc,
  input  wire logic [bfc_pkg::SEL_W-1:0]     shift_sel,
  input  wire logic [bfc_pkg::NUM_CH-1:0]    shift_onoff,
  input  wire logic                          overheat_in,
  input  wire logic                          heat_warning_in,
  input  wire logic                          ref_short_in,
  input  wire logic [bfc_pkg::NUM_CH-1:0]    open_detect,
  input  wire logic [bfc_pkg::NUM_CH-1:0]    short_detect,
  input  wire logic [bfc_pkg::NUM_CH-1:0]    leak_detect,
  input  wire logic                          status_capture,
  output logic [bfc_pkg::BC_W-1:0]           global_brightness_code,
  output logic [bfc_pkg::NUM_CH-1:0]         sink_output_channel,
  output logic [bfc_pkg::NUM_CH*bfc_pkg::LEVEL_W-1:0] channel_level,
  output logic                               overheat_shutdown,
  output logic                               overheat_error_flag,
  output logic [bfc_pkg::NUM_CH-1:0]         open_led_status,
  output logic [bfc_pkg::NUM_CH-1:0]         shorted_led_status,
  output logic [bfc_pkg::NUM_CH-1:0]         output_leak_status,
  output logic                               reference_short_flag,
  output logic                               heat_warning_flag,
  output logic [bfc_pkg::NUM_ERR-1:0]        error_summary,
  output logic [bfc_pkg::NUM_CH-1:0]         status_word
);
  import bfc_pkg::*;

  function automatic logic [NUM_CH-1:0] fill(input logic b);
    fill = {NUM_CH{b}};
  endfunction : fill

  logic [1:0]        hot_sync_q;
  logic [1:0]        hot_sync_d;
  logic [BC_W-1:0]   bc_q;
  logic [BC_W-1:0]   bc_d;
  logic [SEL_W-1:0]  sel_q;
  logic [SEL_W-1:0]  sel_d;
  logic [NUM_CH-1:0] onoff_q;
  logic [NUM_CH-1:0] onoff_d;
  logic              tef_q;
  logic              tef_d;
  bfc_state_e        state_q;
  bfc_state_e        state_d;
  logic [NUM_CH-1:0] open_q;
  logic [NUM_CH-1:0] open_d;
  logic [NUM_CH-1:0] short_q;
  logic [NUM_CH-1:0] short_d;
  logic [NUM_CH-1:0] leak_q;
  logic [NUM_CH-1:0] leak_d;
  logic [NUM_CH-1:0] sw_q;
  logic [NUM_CH-1:0] sw_d;
  logic              ref_q;
  logic              ref_d;
  logic              warn_q;
  logic              warn_d;
  logic [NUM_CH-1:0] outs_q;
  logic [NUM_CH-1:0] outs_d;
  logic [NUM_CH-1:0] open_raw;
  logic [NUM_CH-1:0] short_raw;
  logic              hot;

  // Only the second synchroniser stage is used by the logic
  assign hot = hot_sync_q[1];

  // Per-channel masking of the raw open and short detectors by the on/off latch
  for (genvar g = 0; g < NUM_CH; g++) begin : gen_chan
    assign open_raw[g]  = open_detect[g] & onoff_q[g]; // [RULE_14]
    assign short_raw[g] = short_detect[g] & onoff_q[g];
  end

  // Overheat synchroniser
  always_comb begin
    hot_sync_d = {hot_sync_q[0], overheat_in}; // [RULE_15]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hot_sync_q <= 2'h0;
    end else if (clk_en) begin
      hot_sync_q <= hot_sync_d;
    end
  end

  // Brightness, status select and on/off latches
  always_comb begin
    bc_d    = bc_q;
    sel_d   = sel_q;
    onoff_d = onoff_q;
    if (latch_strobe && load_control) begin
      bc_d  = shift_bc;  // [RULE_04] [RULE_01]
      sel_d = shift_sel;
    end else if (latch_strobe) begin
      onoff_d = shift_onoff; // [RULE_12]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bc_q    <= BC_RESET;
      sel_q   <= SEL_RESET;
      onoff_q <= ONOFF_RESET;
    end else if (clk_en) begin
      bc_q    <= bc_d;
      sel_q   <= sel_d;
      onoff_q <= onoff_d;
    end
  end

  // Shutdown state and sticky error flag
  always_comb begin
    state_d = state_q;
    case (state_q)
      BFC_RUN: begin
        if (hot) begin
          state_d = BFC_SHUTDOWN; // [RULE_08]
        end
      end
      BFC_SHUTDOWN: begin
        if (!hot) begin
          state_d = BFC_RUN; // [RULE_10]
        end
      end
      default: begin
        state_d = BFC_RUN;
      end
    endcase
    // Set wins over the strobe clear
    tef_d = hot ? 1'b1 : (latch_strobe ? 1'b0 : tef_q); // [RULE_11]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= BFC_RUN;
      tef_q   <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      tef_q   <= tef_d;
    end
  end

  // Sink drive, forced off by shutdown or reference short
  always_comb begin
    outs_d = (state_q == BFC_SHUTDOWN || hot || ref_short_in) ? fill(1'b0)
                                                             : onoff_q; // [RULE_05] [RULE_08]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outs_q <= '0;
    end else if (clk_en) begin
      outs_q <= outs_d;
    end
  end

  // Error status and the captured status word
  always_comb begin
    open_d  = (state_q == BFC_SHUTDOWN) ? fill(1'b1) : open_raw; // [RULE_09] [RULE_14]
    short_d = warn_q ? fill(1'b1) : short_raw; // [RULE_06]
    leak_d  = ref_q ? fill(1'b1) : leak_detect; // [RULE_06]
    ref_d   = ref_short_in;
    warn_d  = heat_warning_in;
    sw_d    = sw_q;
    if (status_capture) begin
      case (sel_q)
        SEL_OPEN:  sw_d = tef_q ? fill(1'b1) : open_q; // [RULE_13] [RULE_07]
        SEL_SHORT: sw_d = warn_q ? fill(1'b1) : short_q;
        SEL_LEAK:  sw_d = ref_q ? fill(1'b1) : leak_q;
        default:   sw_d = fill(1'b0);
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      open_q  <= '0;
      short_q <= '0;
      leak_q  <= '0;
      sw_q    <= '0;
      ref_q   <= 1'b0;
      warn_q  <= 1'b0;
    end else if (clk_en) begin
      open_q  <= open_d;
      short_q <= short_d;
      leak_q  <= leak_d;
      sw_q    <= sw_d;
      ref_q   <= ref_d;
      warn_q  <= warn_d;
    end
  end

  bfc_level_scale u_scale (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .code     (bc_q),     // [RULE_02] [RULE_03]
    .chan_on  (outs_d),
    .level_q  (channel_level)
  );

  assign global_brightness_code = bc_q;
  assign sink_output_channel    = outs_q;
  assign overheat_shutdown      = (state_q == BFC_SHUTDOWN);
  assign overheat_error_flag    = tef_q;
  assign open_led_status        = open_q;
  assign shorted_led_status     = short_q;
  assign output_leak_status     = leak_q;
  assign reference_short_flag   = ref_q;
  assign heat_warning_flag      = warn_q;
  assign status_word            = sw_q;
  assign error_summary = {tef_q, warn_q, ref_q, |leak_q, |short_q, |open_q}; // [RULE_06]

  chk_sync_delay: assert property (@(posedge core_clk) disable iff (rst) // [RULE_15]
    clk_en [*3] |-> hot == $past(overheat_in, 2))
    else $error("sync check");
  chk_hot_outputs_off: assert property (@(posedge core_clk) disable iff (rst) // [RULE_08]
    overheat_shutdown |-> sink_output_channel == '0)
    else $error("outputs not off during shutdown");
  chk_open_forced: assert property (@(posedge core_clk) disable iff (rst) // [RULE_09]
    clk_en && overheat_shutdown |=> !clk_en || open_led_status == fill(1'b1))
    else $error("open status not forced");
  chk_flag_holds: assert property (@(posedge core_clk) disable iff (rst) // [RULE_11]
    overheat_error_flag && !latch_strobe && !hot |=> overheat_error_flag)
    else $error("error flag dropped without strobe");
  chk_flag_clear: assert property (@(posedge core_clk) disable iff (rst) // [RULE_11]
    clk_en && latch_strobe && !hot |=> !clk_en || !overheat_error_flag)
    else $error("error flag not cleared by strobe");
  chk_onoff_strobe: assert property (@(posedge core_clk) disable iff (rst) // [RULE_12]
    !latch_strobe |=> $stable(onoff_q))
    else $error("on/off changed without strobe");
  chk_bc_load: assert property (@(posedge core_clk) disable iff (rst) // [RULE_04]
    clk_en && latch_strobe && load_control |=> global_brightness_code == $past(shift_bc))
    else $error("brightness not loaded");
  chk_open_masked: assert property (@(posedge core_clk) disable iff (rst) // [RULE_14]
    clk_en && !overheat_shutdown |=> (open_led_status & ~$past(onoff_q)) == '0)
    else $error("open status on disabled channel");
  chk_resume: assert property (@(posedge core_clk) disable iff (rst) // [RULE_10]
    clk_en [*2] ##0 (state_q == BFC_RUN && !hot && !ref_short_in)
      |=> !clk_en || sink_output_channel == $past(onoff_q))
    else $error("outputs did not follow on/off data");
  chk_all_ones: assert property (@(posedge core_clk) disable iff (rst) // [RULE_13]
    clk_en && status_capture && sel_q == SEL_OPEN && tef_q |=> status_word == fill(1'b1))
    else $error("status word not all ones");
  chk_short_ones: assert property (@(posedge core_clk) disable iff (rst) // [RULE_07]
    clk_en && status_capture && sel_q == SEL_SHORT && warn_q |=> status_word == fill(1'b1))
    else $error("short status word not all ones");
  chk_leak_ones: assert property (@(posedge core_clk) disable iff (rst) // [RULE_07]
    clk_en && status_capture && sel_q == SEL_LEAK && ref_q |=> status_word == fill(1'b1))
    else $error("leak status word not all ones");
  chk_zero_select: assert property (@(posedge core_clk) disable iff (rst) // [RULE_07]
    clk_en && status_capture && sel_q == SEL_RESET |=> status_word == '0)
    else $error("status word not zero for select 00");
  chk_word_hold: assert property (@(posedge core_clk) disable iff (rst) // [RULE_07]
    !status_capture |=> $stable(status_word))
    else $error("status word changed without capture");
  chk_warn_short: assert property (@(posedge core_clk) disable iff (rst) // [RULE_06]
    clk_en && heat_warning_flag |=> !clk_en || shorted_led_status == fill(1'b1))
    else $error("short status not forced by warning");
  chk_ref_leak: assert property (@(posedge core_clk) disable iff (rst) // [RULE_06]
    clk_en && reference_short_flag |=> !clk_en || output_leak_status == fill(1'b1))
    else $error("leak status not forced by reference short");
  chk_ref_off: assert property (@(posedge core_clk) disable iff (rst) // [RULE_05]
    reference_short_flag |-> sink_output_channel == '0)
    else $error("outputs on during reference short");
  chk_bc_hold: assert property (@(posedge core_clk) disable iff (rst) // [RULE_01]
    !latch_strobe |=> $stable(global_brightness_code))
    else $error("brightness changed without strobe");
  chk_onoff_load: assert property (@(posedge core_clk) disable iff (rst) // [RULE_12]
    clk_en && latch_strobe && !load_control |=> onoff_q == $past(shift_onoff))
    else $error("on/off word not latched");
  chk_level_off: assert property (@(posedge core_clk) disable iff (rst) // [RULE_03]
    !sink_output_channel[0] |-> channel_level[LEVEL_W-1:0] == '0)
    else $error("level on a channel that is off");
  chk_freeze: assert property (@(posedge core_clk) disable iff (rst) // [RULE_05]
    !clk_en |=> $stable(sink_output_channel) && $stable(overheat_error_flag))
    else $error("state changed while clock enable low");

  cov_shutdown: cover property (@(posedge core_clk) disable iff (rst) $rose(overheat_shutdown));
  cov_flag_clear: cover property (@(posedge core_clk) disable iff (rst)
    $fell(overheat_error_flag));
  cov_bc_load: cover property (@(posedge core_clk) disable iff (rst) latch_strobe && load_control);
  cov_warn_word: cover property (@(posedge core_clk) disable iff (rst)
    status_capture && sel_q == SEL_SHORT && warn_q);
  cov_freeze: cover property (@(posedge core_clk) disable iff (rst) !clk_en && latch_strobe);
endmodule : bfc_ctrl

// [src/bfc_level_scale.sv]
// Registered level scaler: level = code * 255 / 127, one output per channel
// Assumes the caller gates channel enables; clock enable freezes the register
module bfc_level_scale
  import bfc_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic                          clk_en,
  input  wire logic [bfc_pkg::BC_W-1:0]      code,
  input  wire logic [bfc_pkg::NUM_CH-1:0]    chan_on,
  output logic [bfc_pkg::NUM_CH*bfc_pkg::LEVEL_W-1:0] level_q
);
  logic [NUM_CH*LEVEL_W-1:0] level_d;
  logic [LEVEL_W-1:0]        scaled;
  logic [15:0]               prod;

  // Linear map over 128 codes, 0 gives zero and 7F gives full scale
  assign prod   = {9'h000, code} * 16'h00FF;
  assign scaled = 8'(prod / 16'(BC_FULL));

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      level_d[i*LEVEL_W +: LEVEL_W] = chan_on[i] ? scaled : 8'h00; // [RULE_03]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_q <= '0;
    end else if (clk_en) begin
      level_q <= level_d;
    end
  end

  chk_full_scale: assert property (@(posedge core_clk) disable iff (rst) // [RULE_03]
    clk_en && code == BC_FULL && chan_on[0] |=> level_q[LEVEL_W-1:0] == LEVEL_FULL)
    else $error("full code did not give full level");
endmodule : bfc_level_scale

// [src/bfc_pkg.sv]
// Package: shared constants for the brightness and thermal flag control block
// Assumes a single core clock and plain ports, no register bus
package bfc_pkg;
  localparam int          NUM_CH        = 16;
  localparam int          BC_W          = 7;
  localparam int          LEVEL_STEPS   = 128;
  localparam logic [6:0]  BC_FULL       = 7'h7F;
  localparam logic [6:0]  BC_RESET      = 7'h00;
  localparam logic [15:0] ONOFF_RESET   = 16'h0000;
  localparam int          LEVEL_W       = 8;
  localparam logic [7:0]  LEVEL_FULL    = 8'hFF;
  localparam int          NUM_ERR       = 6;
  localparam int          ERR_OPEN      = 0;
  localparam int          ERR_SHORT     = 1;
  localparam int          ERR_LEAK      = 2;
  localparam int          ERR_REF       = 3;
  localparam int          ERR_WARN      = 4;
  localparam int          ERR_HOT       = 5;
  localparam int          SEL_W         = 2;
  localparam logic [1:0]  SEL_OPEN      = 2'h1;
  localparam logic [1:0]  SEL_SHORT     = 2'h2;
  localparam logic [1:0]  SEL_LEAK      = 2'h3;
  localparam logic [1:0]  SEL_RESET     = 2'h0;
  typedef enum logic [0:0] {BFC_RUN, BFC_SHUTDOWN} bfc_state_e;
endpackage : bfc_pkg

// [test/bfc_host.sv]
// Host model: presents shift words, latch strobe and status capture
// Assumes the block samples on rising core_clk; drives at falling edge
module bfc_host
  import bfc_pkg::*;
(
  input  wire logic                   core_clk,
  output logic                        latch_strobe,
  output logic                        load_control,
  output logic [bfc_pkg::BC_W-1:0]    shift_bc,
  output logic [bfc_pkg::SEL_W-1:0]   shift_sel,
  output logic [bfc_pkg::NUM_CH-1:0]  shift_onoff,
  output logic                        status_capture
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    latch_strobe = 1'b0;
    load_control = 1'b0;
    shift_bc = 7'h00;
    shift_sel = 2'h0;
    shift_onoff = 16'h0000;
    status_capture = 1'b0;
  end
  task automatic send(input logic ctl, input logic [6:0] bc, input logic [15:0] w);
    @(negedge core_clk);
    load_control = ctl;
    shift_bc = bc;
    shift_sel = SEL_OPEN;
    shift_onoff = w;
    latch_strobe = 1'b1;
    @(negedge core_clk);
    latch_strobe = 1'b0;
  endtask : send
  task automatic load_sel(input logic [1:0] sel, input logic [6:0] bc);
    @(negedge core_clk);
    load_control = 1'b1;
    shift_bc = bc;
    shift_sel = sel;
    latch_strobe = 1'b1;
    @(negedge core_clk);
    latch_strobe = 1'b0;
    load_control = 1'b0;
  endtask : load_sel
  task automatic shift_only(input logic [15:0] w);
    @(negedge core_clk);
    shift_onoff = w;
  endtask : shift_only
  task automatic capture();
    @(negedge core_clk);
    status_capture = 1'b1;
    @(negedge core_clk);
    status_capture = 1'b0;
  endtask : capture
endmodule : bfc_host

// [test/test_brightness_thermal_flag_control.sv]
// Testbench: table of brightness and on/off rows, then overheat sequence
// Assumes a 20 MHz core clock and the host model beside the block
module test_brightness_thermal_flag_control
  import bfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [6:0] bc; logic [15:0] w; logic [7:0] l0; logic [7:0] l15;} bfc_row_s;
  logic core_clk, rst, clk_en, overheat_in, heat_warning_in, ref_short_in;
  logic latch_strobe, load_control, status_capture;
  logic [6:0] shift_bc, global_brightness_code;
  logic [1:0] shift_sel;
  logic [15:0] shift_onoff, open_detect, short_detect, leak_detect;
  logic [15:0] sink_output_channel, open_led_status, status_word;
  logic [15:0] shorted_led_status, output_leak_status;
  logic reference_short_flag, heat_warning_flag;
  logic [127:0] channel_level;
  logic overheat_shutdown, overheat_error_flag;
  logic [5:0] error_summary;
  int fail_count = 0;
  int num_checks = 0;
  bfc_row_s rows [5] = '{'{7'h7F, 16'hFFFF, 8'hFF, 8'hFF}, '{7'h01, 16'h8001, 8'h02, 8'h02},
    '{7'h40, 16'h0001, 8'h80, 8'h00}, '{7'h00, 16'hFFFF, 8'h00, 8'h00},
    '{7'h2F, 16'h8000, 8'h00, 8'h5E}};
  bfc_host bfc_host_inst (.core_clk(core_clk), .latch_strobe(latch_strobe),
    .load_control(load_control), .shift_bc(shift_bc), .shift_sel(shift_sel),
    .shift_onoff(shift_onoff), .status_capture(status_capture));
  bfc_ctrl bfc_ctrl_inst (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .latch_strobe(latch_strobe), .load_control(load_control), .shift_bc(shift_bc),
    .shift_sel(shift_sel), .shift_onoff(shift_onoff), .overheat_in(overheat_in),
    .heat_warning_in(heat_warning_in), .ref_short_in(ref_short_in),
    .open_detect(open_detect), .short_detect(short_detect), .leak_detect(leak_detect),
    .status_capture(status_capture), .global_brightness_code(global_brightness_code),
    .sink_output_channel(sink_output_channel), .channel_level(channel_level),
    .overheat_shutdown(overheat_shutdown), .overheat_error_flag(overheat_error_flag),
    .open_led_status(open_led_status), .shorted_led_status(shorted_led_status),
    .output_leak_status(output_leak_status), .reference_short_flag(reference_short_flag),
    .heat_warning_flag(heat_warning_flag), .error_summary(error_summary),
    .status_word(status_word));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #200us;
    fail_count++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    overheat_in = 1'b0;
    heat_warning_in = 1'b0;
    ref_short_in = 1'b0;
    open_detect = 16'h0000;
    short_detect = 16'h0000;
    leak_detect = 16'h0000;
    wait_n(6);
    rst = 1'b0;
    wait_n(2);
    chk("bc_rst", 16'(global_brightness_code), 16'h0000);
    chk("out_rst", sink_output_channel, 16'h0000);
    foreach (rows[i]) begin
      bfc_host_inst.send(1'b1, rows[i].bc, 16'h0000);
      bfc_host_inst.send(1'b0, rows[i].bc, rows[i].w);
      wait_n(3);
      chk("bc", 16'(global_brightness_code), 16'(rows[i].bc));
      chk("out", sink_output_channel, rows[i].w);
      chk("lvl0", 16'(channel_level[7:0]), 16'(rows[i].l0));
      chk("lvl15", 16'(channel_level[127:120]), 16'(rows[i].l15));
    end
    bfc_host_inst.shift_only(16'h0F0F);
    wait_n(4);
    chk("no_strobe", sink_output_channel, 16'h8000);
    bfc_host_inst.send(1'b0, 7'h00, 16'h00FF);
    open_detect = 16'hFFFF;
    wait_n(4);
    chk("open_mask", open_led_status, 16'h00FF);
    overheat_in = 1'b1;
    wait_n(1);
    chk("sync", 16'(overheat_shutdown), 16'h0000);
    wait_n(5);
    chk("hot_out", sink_output_channel, 16'h0000);
    chk("hot_open", open_led_status, 16'hFFFF);
    chk("hot_sum", 16'(error_summary[ERR_HOT]), 16'h0001);
    bfc_host_inst.capture();
    wait_n(3);
    chk("hot_word", status_word, 16'hFFFF);
    bfc_host_inst.send(1'b0, 7'h00, 16'h00FF);
    wait_n(3);
    chk("set_wins", 16'(overheat_error_flag), 16'h0001);
    overheat_in = 1'b0;
    wait_n(6);
    chk("resume", sink_output_channel, 16'h00FF);
    chk("sticky", 16'(overheat_error_flag), 16'h0001);
    bfc_host_inst.send(1'b0, 7'h00, 16'h00FF);
    wait_n(3);
    chk("cleared", 16'(overheat_error_flag), 16'h0000);
    bfc_host_inst.load_sel(SEL_SHORT, 7'h10);
    short_detect = 16'h0F03;
    wait_n(3);
    chk("short_mask", shorted_led_status, 16'h0003);
    heat_warning_in = 1'b1;
    wait_n(3);
    chk("warn_flag", 16'(heat_warning_flag), 16'h0001);
    chk("warn_short", shorted_led_status, 16'hFFFF);
    chk("warn_out", sink_output_channel, 16'h00FF);
    bfc_host_inst.capture();
    wait_n(2);
    chk("warn_word", status_word, 16'hFFFF);
    heat_warning_in = 1'b0;
    ref_short_in = 1'b1;
    bfc_host_inst.load_sel(SEL_LEAK, 7'h10);
    wait_n(3);
    chk("ref_flag", 16'(reference_short_flag), 16'h0001);
    chk("ref_out", sink_output_channel, 16'h0000);
    chk("ref_leak", output_leak_status, 16'hFFFF);
    chk("ref_sum", 16'(error_summary[ERR_REF:ERR_LEAK]), 16'h0003);
    bfc_host_inst.capture();
    wait_n(2);
    chk("leak_word", status_word, 16'hFFFF);
    ref_short_in = 1'b0;
    bfc_host_inst.load_sel(SEL_RESET, 7'h10);
    bfc_host_inst.capture();
    wait_n(2);
    chk("zero_word", status_word, 16'h0000);
    wait_n(3);
    clk_en = 1'b0;
    bfc_host_inst.send(1'b0, 7'h00, 16'h0F0F);
    wait_n(2);
    chk("freeze", sink_output_channel, 16'h00FF);
    clk_en = 1'b1;
    wait_n(3);
    chk("thaw", sink_output_channel, 16'h00FF);
    finish_test();
  end
endmodule : test_brightness_thermal_flag_control
